// file: rtl/bcs_regs.sv
// Decided for this implementation: the Wishbone slave port.
`include "bcs_defs.svh"

module bcs_regs (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic unlocked_i,
  input wire logic tile_supported_i,
  input wire logic [23:0] tile_ident_i,
  input wire logic pb_reset_i,
  input wire logic [7:0] osc_tick_i,
  input wire logic [31:0] ser_rdata_i,
  input wire logic ser_rvalid_i,
  output bcs_pkg::bcs_ser_req_t ser_o,
  output bcs_pkg::bcs_cfg_t cfg_o,
  output logic alias_db_o,
  output logic [7:0][31:0] osc_live_o,
  output logic osc_load_o
);

  bcs_pkg::bcs_state_t s;
  bcs_pkg::bcs_state_t n;
  logic req;
  logic wr_ok;
  logic [31:0] wmask;

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] val,
    input logic [3:0] sel
  );
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = val[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Oscillator reset-value slot, 4'hf when no match
  function automatic logic [3:0] oscr_idx(input logic [31:0] a);
    unique case (a)
      `BCS_A_OSCR0: oscr_idx = 4'h0;
      `BCS_A_OSCR1: oscr_idx = 4'h1;
      `BCS_A_OSCR2: oscr_idx = 4'h2;
      `BCS_A_OSCR3: oscr_idx = 4'h3;
      `BCS_A_OSCR4: oscr_idx = 4'h4;
      `BCS_A_OSCR5: oscr_idx = 4'h5;
      `BCS_A_OSCR6: oscr_idx = 4'h6;
      `BCS_A_OSCR7: oscr_idx = 4'h7;
      default: oscr_idx = 4'hf;
    endcase
  endfunction

  // Test counter slot, 4'hf when no match
  function automatic logic [3:0] cnt_idx(input logic [31:0] a);
    unique case (a)
      `BCS_A_CNT0: cnt_idx = 4'h0;
      `BCS_A_CNT1: cnt_idx = 4'h1;
      `BCS_A_CNT2: cnt_idx = 4'h2;
      `BCS_A_CNT3: cnt_idx = 4'h3;
      `BCS_A_CNT4: cnt_idx = 4'h4;
      `BCS_A_CNT5: cnt_idx = 4'h5;
      `BCS_A_CNT6: cnt_idx = 4'h6;
      `BCS_A_CNT7: cnt_idx = 4'h7;
      default: cnt_idx = 4'hf;
    endcase
  endfunction

  // New request: the answer flop gates it so one access gets one ack
  assign req = wb_cyc_i & wb_stb_i & ~s.ack & ~s.err;
  assign wr_ok = req & wb_we_i & unlocked_i;
  assign wmask = wb_dat_i;

  // Next state of the whole bank
  always_comb begin
    logic [3:0] oi;
    logic [3:0] ci;
    oi = oscr_idx(wb_adr_i);
    ci = cnt_idx(wb_adr_i);
    n = s;
    n.ack = 1'b0;
    n.err = 1'b0;
    n.swr = 1'b0;
    n.srd = 1'b0;
    n.live_ld = 1'b0;
    // Counter 7 has no oscillator of its own; it follows source 6
    for (int i = 0; i < 8; i++) begin
      if (osc_tick_i[(i == 7) ? 6 : i]) begin
        n.cnt[i] = s.cnt[i] + 32'h1;
      end
    end
    // Stream read data lands after the read that asked for it
    if (ser_rvalid_i) begin
      n.payload = ser_rdata_i;
    end
    if (req) begin
      n.ack = 1'b1;
      n.dat = 32'h0;
      if (wb_adr_i == `BCS_A_PAYLOAD) begin
        n.dat = s.payload;
        if (!wb_we_i) begin
          n.srd = 1'b1;
        end else if (wr_ok) begin
          n.payload = merge(s.payload, wmask, wb_sel_i);
          n.swr = 1'b1;
        end
      end else if (wb_adr_i == `BCS_A_SADDR) begin
        n.dat = {20'h0, s.saddr};
        if (wr_ok) begin
          n.saddr = merge({20'h0, s.saddr}, wmask, wb_sel_i)
            [`BCS_SADDR_W-1:0];
        end
      end else if (wb_adr_i == `BCS_A_PROCID) begin
        // Low bits only carry a tile ident when a tile can report one
        n.dat = tile_supported_i ?
          {`BCS_PROC_CODE, tile_ident_i} :
          {`BCS_NO_TILE_CODE, 24'h0};
      end else if (wb_adr_i == `BCS_A_GFX) begin
        n.dat = s.gfx;
        if (wr_ok) begin
          n.gfx = merge(s.gfx, wmask, wb_sel_i);
        end
      end else if (oi != 4'hf) begin
        n.dat = s.oscr[oi[2:0]];
        if (wr_ok) begin
          n.oscr[oi[2:0]] = merge(s.oscr[oi[2:0]], wmask, wb_sel_i);
        end
      end else if (ci != 4'hf) begin
        n.dat = s.cnt[ci[2:0]];
      end else begin
        n.ack = 1'b0;
        n.err = 1'b1;
      end
    end
    // Push-button: reload live settings, restart the test counters
    if (pb_reset_i) begin
      n.live = s.oscr;
      n.live_ld = 1'b1;
      n.cnt = '0;
    end
    n.alias_db = (n.payload.alias_sel == `BCS_ALIAS_DB);
  end

  // Power-on reset; the stream side keeps its own copy over soft resets
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
      s.payload <= `BCS_PAYLOAD_RST;
      s.gfx <= `BCS_GFX_RST;
      s.oscr <= {8{`BCS_OSC_RST}};
      s.live <= {8{`BCS_OSC_RST}};
    end else begin
      s <= n;
    end
  end

  assign wb_ack_o = s.ack;
  assign wb_err_o = s.err;
  assign wb_dat_o = s.dat;
  assign cfg_o = s.payload;
  assign alias_db_o = s.alias_db;
  assign osc_live_o = s.live;
  assign osc_load_o = s.live_ld;
  // Stream address and data are the registers themselves
  assign ser_o.wr = s.swr;
  assign ser_o.rd = s.srd;
  assign ser_o.stream_target_address = s.saddr;
  assign ser_o.data = s.payload;

  sequence seq_wr(logic [31:0] a);
    req && wb_we_i && unlocked_i && wb_adr_i == a && wb_sel_i == 4'hf;
  endsequence

  sequence seq_rd(logic [31:0] a);
    req && !wb_we_i && wb_adr_i == a;
  endsequence

  AST_DEBUG_RST: assert property (@(posedge clk_i)
    $past(rst_i) && !rst_i |-> cfg_o[19:16] == 4'hf && cfg_o[31:20] == 12'h0)
    else $error("payload reset value wrong");

  AST_LOCKED_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    req && wb_we_i && !unlocked_i && wb_adr_i == `BCS_A_GFX |=> $stable(s.gfx))
    else $error("locked write changed register");

  AST_SADDR_RD: assert property (@(posedge clk_i) disable iff (rst_i)
    seq_rd(`BCS_A_SADDR) |=> wb_ack_o && wb_dat_o[31:12] == 20'h0)
    else $error("stream address upper bits not zero");

  AST_SER_WR: assert property (@(posedge clk_i) disable iff (rst_i)
    seq_wr(`BCS_A_PAYLOAD) && !ser_rvalid_i |=> ser_o.wr && !ser_o.rd
      && ser_o.data == $past(wb_dat_i) ##1 !ser_o.wr)
    else $error("payload write not sent once");

  AST_SER_RD: assert property (@(posedge clk_i) disable iff (rst_i)
    seq_rd(`BCS_A_PAYLOAD) |=> ser_o.rd && wb_dat_o == $past(s.payload))
    else $error("payload read did not start stream read");

  AST_PB_COPY: assert property (@(posedge clk_i) disable iff (rst_i)
    pb_reset_i |=> osc_load_o && osc_live_o == $past(s.oscr))
    else $error("push-button copy missing");

  AST_CNT7_SRC: assert property (@(posedge clk_i) disable iff (rst_i)
    osc_tick_i[6] && !pb_reset_i |=> s.cnt[7] == $past(s.cnt[7]) + 32'h1)
    else $error("counter 7 not following source 6");

  AST_NO_TILE: assert property (@(posedge clk_i) disable iff (rst_i)
    seq_rd(`BCS_A_PROCID) && !tile_supported_i |=> wb_dat_o[23:0] == 24'h0)
    else $error("tile ident not zero");

  AST_ALIAS: assert property (@(posedge clk_i) disable iff (rst_i)
    alias_db_o |-> cfg_o.alias_sel == 3'h1)
    else $error("alias decode wrong");

  AST_OSC_WR: assert property (@(posedge clk_i) disable iff (rst_i)
    seq_wr(`BCS_A_OSCR5) |=> s.oscr[5] == $past(wb_dat_i) ##1 !wb_ack_o)
    else $error("oscillator reset write lost");

endmodule

// file: rtl/bcs_defs.svh
`ifndef BCS_DEFS_SVH
`define BCS_DEFS_SVH
// Summary of operation
// - Per-CPU nonmaskable fast interrupt bits, reset zero
// - Per-CPU control coprocessor write block, reset zero
// - Per-CPU big-endian boot select, reset zero
// - Four global debug enables, reset to one
// - Per-CPU exception instruction state select, reset zero
// - Per-CPU high exception vectors at reset
// - Cluster number feeds affinity register bits 11:8
// - Alias select: 001 maps daughterboard memory low
// - Stream address is 12 bits, upper reads zero
// - Identity top byte gives fitted processor code when a tile can report, else the no-tile code
// - Identity low bits give tile ident or zero
// - Graphics tile word is lockable 32-bit read/write
// - Eight read/write oscillator reset-value registers
// - Power-on reset loads oscillator defaults
// - Push-button copies reset values to live settings
// - Test counters count oscillator ticks, reset zero
// - Eighth counter is clocked like the seventh
// - Payload write is sent to stream address
// - Payload read starts stream read, updates later

// Register byte addresses
`define BCS_A_PAYLOAD 32'h1000007c
`define BCS_A_SADDR 32'h10000080
`define BCS_A_PROCID 32'h10000084
`define BCS_A_GFX 32'h10000088
`define BCS_A_OSCR0 32'h1000008c
`define BCS_A_OSCR1 32'h10000090
`define BCS_A_OSCR2 32'h10000094
`define BCS_A_OSCR3 32'h10000098
`define BCS_A_OSCR4 32'h1000009c
`define BCS_A_OSCR5 32'h100000dc
`define BCS_A_OSCR6 32'h100000e0
`define BCS_A_OSCR7 32'h100000f0
`define BCS_A_CNT0 32'h100000c0
`define BCS_A_CNT1 32'h100000c4
`define BCS_A_CNT2 32'h100000c8
`define BCS_A_CNT3 32'h100000cc
`define BCS_A_CNT4 32'h100000d0
`define BCS_A_CNT5 32'h100000e4
`define BCS_A_CNT6 32'h100000e8
`define BCS_A_CNT7 32'h100000f4
// Field positions and reset values
`define BCS_SADDR_W 12
`define BCS_ALIAS_DB 3'h1
`define BCS_PAYLOAD_RST 32'h000f0000
`define BCS_OSC_RST 32'h00000000
// Arbitrary values, not tied to any real part
`define BCS_PROC_CODE 8'h5a
`define BCS_NO_TILE_CODE 8'h3c
`define BCS_GFX_RST 32'h00000000
`endif

// file: rtl/bcs_pkg.sv
package bcs_pkg;
  // Payload field layout, msb first
  typedef struct packed {
    logic [2:0] fast_irq_nonmaskable_per_cpu;
    logic [3:0] sysctl_write_block_per_cpu;
    logic rsvd24;
    logic [3:0] boot_big_endian_per_cpu;
    logic secure_passive_debug_en;
    logic secure_active_debug_en;
    logic passive_debug_en;
    logic active_debug_en;
    logic [3:0] exception_instr_state_per_cpu;
    logic [3:0] high_vectors_per_cpu;
    logic [3:0] cluster_number;
    logic rsvd3;
    logic [2:0] alias_sel;
  } bcs_cfg_t;

  // Request toward the serial stream engine
  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] stream_target_address;
    logic [31:0] data;
  } bcs_ser_req_t;

  typedef struct packed {
    logic ack;
    logic err;
    logic [31:0] dat;
    bcs_cfg_t payload;
    logic [11:0] saddr;
    logic [31:0] gfx;
    logic [7:0][31:0] oscr;
    logic [7:0][31:0] cnt;
    logic [7:0][31:0] live;
    logic live_ld;
    logic swr;
    logic srd;
    logic alias_db;
  } bcs_state_t;
endpackage

// file: dv/bcs_stream_model.sv
module bcs_stream_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire bcs_pkg::bcs_ser_req_t ser_i,
  input wire logic [3:0] lag_i,
  output logic [31:0] rdata_o,
  output logic rvalid_o,
  output logic [31:0] last_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [0:4095];
  logic pend;
  logic [3:0] cnt;
  logic [11:0] ra;
  // Daughterboard store starts cleared; it is never wiped by bank resets
  initial foreach (mem[i]) mem[i] = 32'h0;
  // Idle return word toggles so a stale answer is never mistaken for data
  always @(posedge clk_i) begin
    rvalid_o <= 1'h0;
    rdata_o <= ~rdata_o;
    if (rst_i) begin
      pend <= 1'h0;
      rdata_o <= 32'h0;
    end else if (pend) begin
      if (cnt == 4'h0) begin
        pend <= 1'h0;
        rvalid_o <= 1'h1;
        rdata_o <= mem[ra];
      end else begin
        cnt <= cnt - 4'h1;
      end
    end
    if (ser_i.wr) begin
      mem[ser_i.stream_target_address] <= ser_i.data;
      last_o <= ser_i.data;
    end
    if (ser_i.rd) begin
      pend <= 1'h1;
      ra <= ser_i.stream_target_address;
      cnt <= lag_i;
    end
  end
endmodule

// file: dv/board_config_serial_regs_tb.sv
`include "bcs_defs.svh"

module board_config_serial_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'h0, rst_i = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0;
  logic unl = 1'h0, tsup = 1'h0, pb = 1'h0, e, ack, err, rv, adb, ld;
  logic [31:0] adr = 32'h0, wd = 32'h0, rd, q, v, w, sdat, last;
  logic [3:0] sel = 4'hf, lag = 4'h0;
  logic [23:0] tid = 24'h0;
  logic [7:0] tick = 8'h0;
  logic [11:0] s1;
  logic [7:0][31:0] live;
  logic [31:0] ec [8];
  logic [31:0] oa [8] = '{`BCS_A_OSCR0, `BCS_A_OSCR1, `BCS_A_OSCR2, `BCS_A_OSCR3,
    `BCS_A_OSCR4, `BCS_A_OSCR5, `BCS_A_OSCR6, `BCS_A_OSCR7};
  logic [31:0] ca [8] = '{`BCS_A_CNT0, `BCS_A_CNT1, `BCS_A_CNT2, `BCS_A_CNT3,
    `BCS_A_CNT4, `BCS_A_CNT5, `BCS_A_CNT6, `BCS_A_CNT7};
  bcs_pkg::bcs_ser_req_t ser;
  bcs_pkg::bcs_cfg_t cfg;
  int n_fail = 0, checks_done = 0, cyc_n = 0;

  bcs_regs bcs_regs_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rd),
    .wb_ack_o(ack), .wb_err_o(err), .unlocked_i(unl), .tile_supported_i(tsup),
    .tile_ident_i(tid), .pb_reset_i(pb), .osc_tick_i(tick), .ser_rdata_i(sdat),
    .ser_rvalid_i(rv), .ser_o(ser), .cfg_o(cfg), .alias_db_o(adb), .osc_live_o(live),
    .osc_load_o(ld));
  bcs_stream_model bcs_stream_model_inst (.clk_i(clk_i), .rst_i(rst_i), .ser_i(ser),
    .lag_i(lag), .rdata_o(sdat), .rvalid_o(rv), .last_o(last));

  // 50 MHz bus clock
  initial forever #10 clk_i = ~clk_i;

  // Hang guard: the whole run needs well under this many cycles
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask

  // Classic single cycle; request held until ack or err is sampled high
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= wr;
    adr <= a;
    wd <= d;
    do @(posedge clk_i); while (ack !== 1'h1 && err !== 1'h1);
    q = rd;
    e = err;
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask

  task automatic report_and_stop;
    $display("errors %0d checks %0d", n_fail, checks_done);
    if (n_fail == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    void'($urandom(76));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'h0;
    bus(1'h0, `BCS_A_PAYLOAD, 32'h0);
    chk(q, `BCS_PAYLOAD_RST);
    bus(1'h0, `BCS_A_SADDR, 32'h0);
    chk(q, 32'h0);
    for (int i = 0; i < 8; i++) begin
      bus(1'h0, oa[i], 32'h0);
      chk(q, `BCS_OSC_RST);
      bus(1'h0, ca[i], 32'h0);
      chk(q, 32'h0);
    end
    tsup <= 1'h1;
    tid <= $urandom;
    bus(1'h0, `BCS_A_PROCID, 32'h0);
    chk(q, {`BCS_PROC_CODE, tid});
    tsup <= 1'h0;
    bus(1'h0, `BCS_A_PROCID, 32'h0);
    chk(q, {`BCS_NO_TILE_CODE, 24'h0});
    unl <= 1'h1;
    v = $urandom;
    s1 = v[11:0];
    bus(1'h1, `BCS_A_SADDR, v);
    bus(1'h0, `BCS_A_SADDR, 32'h0);
    chk(q, {20'h0, s1});
    // Every alias code except 010 and 100, random fields around it
    for (int k = 0; k < 8; k++) begin
      // Codes 010 and 100 are kept for port validation, never used here
      if (k == 2 || k == 4) continue;
      v = $urandom;
      v[2:0] = k[2:0];
      bus(1'h1, `BCS_A_PAYLOAD, v);
      repeat (3) @(posedge clk_i);
      chk(cfg, v);
      chk(32'(adb), 32'(k == 1));
      chk(last, v);
    end
    // Park a different word at a second address, then read back through s1
    w = $urandom;
    bus(1'h1, `BCS_A_SADDR, {20'h0, s1 ^ 12'h001});
    bus(1'h1, `BCS_A_PAYLOAD, w);
    bus(1'h1, `BCS_A_SADDR, {20'h0, s1});
    lag <= 4'h9;
    bus(1'h0, `BCS_A_PAYLOAD, 32'h0);
    chk(q, w);
    repeat (14) @(posedge clk_i);
    bus(1'h0, `BCS_A_PAYLOAD, 32'h0);
    chk(q, v);
    repeat (14) @(posedge clk_i);
    unl <= 1'h0;
    bus(1'h1, `BCS_A_PAYLOAD, ~v);
    bus(1'h1, `BCS_A_GFX, ~v);
    bus(1'h0, `BCS_A_PAYLOAD, 32'h0);
    chk(q, v);
    chk(last, w);
    bus(1'h0, `BCS_A_GFX, 32'h0);
    chk(q, `BCS_GFX_RST);
    unl <= 1'h1;
    bus(1'h1, `BCS_A_GFX, w);
    bus(1'h0, `BCS_A_GFX, 32'h0);
    chk(q, w);
    for (int i = 0; i < 8; i++) begin
      ec[i] = $urandom;
      bus(1'h1, oa[i], ec[i]);
      bus(1'h0, oa[i], 32'h0);
      chk(q, ec[i]);
    end
    unl <= 1'h0;
    bus(1'h1, oa[0], ~ec[0]);
    pb <= 1'h1;
    @(posedge clk_i);
    pb <= 1'h0;
    @(posedge clk_i);
    chk(32'(ld), 32'h1);
    @(posedge clk_i);
    for (int i = 0; i < 8; i++) chk(live[i], ec[i]);
    // Random ticks; the last counter follows the seventh oscillator
    for (int i = 0; i < 8; i++) ec[i] = 32'h0;
    repeat (200) begin
      @(posedge clk_i);
      v = $urandom;
      tick <= v[7:0];
      for (int i = 0; i < 8; i++) ec[i] += 32'(v[i == 7 ? 6 : i]);
    end
    @(posedge clk_i);
    tick <= 8'h0;
    for (int i = 0; i < 8; i++) begin
      bus(1'h0, ca[i], 32'h0);
      chk(q, ec[i]);
    end
    // Unmapped place answers with an error and no data
    bus(1'h0, 32'h10000100, 32'h0);
    chk(32'(e), 32'h1);
    chk(q, 32'h0);
    report_and_stop();
  end
endmodule
